// *** rtl/nco_defines.vh ***
// constants for the phase accumulator oscillator: field positions, reset values, widths
// assumes the includer runs on a single clock and wants plain `define names
//
// What this block does
// - 20-bit accumulator, software readable and writable bytewise
// - each enabled clock tick adds buffered increment
// - adder carry out is the raw overflow
// - overflow rate equals clock times increment over 2^20
// - overflow timing jitter at most one clock
// - 20-bit increment in low, high, upper bytes
// - adder uses hidden buffered increment copy
// - enabled: low write loads buffers two ticks later
// - disabled: any increment write loads buffers one clock later
// - hidden buffers have no software access path
// - clock source select picks the adder tick source
// - fixed duty mode toggles output per overflow
// - pulse mode width is 1 to 128 ticks
// - overflow sets sticky flag until software clears it
// - polarity bit inverts output; pulse active high
`ifndef NCO_DEFINES_VH
`define NCO_DEFINES_VH

`define ACC_WIDTH        20
`define ACC_RESET        20'h00000
`define INC_RESET        20'h00000
`define LOW_BYTE_LSB     0
`define HIGH_BYTE_LSB    8
`define UPPER_BYTE_LSB   16
`define UPPER_BYTE_WIDTH 4
`define SRC_SEL_WIDTH    4
`define PWS_WIDTH        3
`define PULSE_CNT_WIDTH  8
`define LOAD_DELAY_TICKS 2'h2

`endif

// *** rtl/nco_pulse_shaper.v ***
// output stage: fixed duty toggle or pulse of programmable width, then polarity
// assumes tick_i is a one-cycle strobe marking an adder clock edge, same clock domain
`timescale 1ns/1ns
`default_nettype none
`include "nco_defines.vh"

module nco_pulse_shaper (
    input  wire                        sys_clk_i,     // system clock
    input  wire                        rstn_i,        // async reset, active low
    input  wire                        enable_i,      // block enable
    input  wire                        tick_i,        // adder clock edge strobe
    input  wire                        carry_i,       // overflow on this tick
    input  wire                        pulse_mode_i,  // 1 pulse mode, 0 fixed duty
    input  wire [`PWS_WIDTH-1:0]       width_sel_i,   // pulse width code
    input  wire                        invert_i,      // output invert
    output wire                        out_o          // shaped output
);

    reg                        level;
    reg [`PULSE_CNT_WIDTH-1:0] remain;

    ////////////////////////////////////////////////////////////////////////////////////////
    // the overflow tick itself raises (pulse) or toggles (fixed duty) the output, so it changes from the edge after it
    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            level  <= 1'b0;
            remain <= 8'h00;
        end else if (!enable_i) begin
            level  <= 1'b0;
            remain <= 8'h00;
        end else if (tick_i) begin
            if (!pulse_mode_i) begin
                remain <= 8'h00;
                if (carry_i)
                    level <= ~level;
            end else if (carry_i) begin
                // width 2^n ticks; a new overflow restarts the window
                level  <= 1'b1;
                remain <= (8'h01 << width_sel_i) - 8'h01;
            end else if (remain != 8'h00) begin
                remain <= remain - 8'h01;
            end else begin
                level <= 1'b0;
            end
        end
    end

    // polarity last, so the reported level matches the pin
    assign out_o = level ^ invert_i;

endmodule

`default_nettype wire

// *** rtl/phase_accumulator_oscillator.v ***
// numerically controlled oscillator: 20-bit phase accumulator with buffered increment
// assumes software-side write strobes are one-cycle pulses on sys_clk_i; clock
// sources arrive asynchronous and pass a two-flop synchroniser before edge detection
`timescale 1ns/1ns
`default_nettype none
`include "nco_defines.vh"

module phase_accumulator_oscillator #(
    parameter SOURCES = 16                                     // selectable clock inputs
) (
    input  wire                        sys_clk_i,              // system clock, 25 MHz
    input  wire                        rstn_i,                 // async reset, active low
    input  wire                        enable_i,               // module enable
    input  wire                        pulse_mode_select_i,    // 1 pulse, 0 fixed duty
    input  wire [`PWS_WIDTH-1:0]       pulse_width_select_i,   // width 2^n ticks
    input  wire                        output_invert_i,        // invert output
    input  wire [`SRC_SEL_WIDTH-1:0]   clock_source_select_i,  // tick source
    input  wire [SOURCES-1:0]          clock_sources_i,        // async candidate clocks
    input  wire [7:0]                  wdata_i,                // software write byte
    input  wire                        inc_low_we_i,           // write increment low
    input  wire                        inc_high_we_i,          // write increment high
    input  wire                        inc_upper_we_i,         // write increment upper
    input  wire                        acc_low_we_i,           // write accumulator low
    input  wire                        acc_high_we_i,          // write accumulator high
    input  wire                        acc_upper_we_i,         // write accumulator upper
    input  wire                        flag_clear_i,           // clear event flag
    output wire [7:0]                  increment_low_byte_o,   // increment holding low
    output wire [7:0]                  increment_high_byte_o,  // increment holding high
    output wire [7:0]                  increment_upper_byte_o, // increment holding upper
    output wire [7:0]                  accumulator_low_byte_o, // accumulator low
    output wire [7:0]                  accumulator_high_byte_o,// accumulator high
    output wire [7:0]                  accumulator_upper_byte_o,// accumulator upper
    output reg                         accumulator_carry_out_o,// raw overflow, one tick
    output reg                         overflow_event_flag_o,  // sticky overflow flag
    output wire                        oscillator_out_o        // shaped output
);

    reg  [`ACC_WIDTH-1:0] acc;
    reg  [`ACC_WIDTH-1:0] inc_hold;
    reg  [`ACC_WIDTH-1:0] inc_buf;
    reg  [SOURCES-1:0]    src_meta;
    reg  [SOURCES-1:0]    src_sync;
    reg                   src_prev;
    reg                   load_pend;
    reg  [1:0]            load_cnt;
    wire                  src_level;
    wire                  tick;
    wire [`ACC_WIDTH:0]   sum;

    ////////////////////////////////////////////////////////////////////////////////////////
    // synchronise every source, then select; selecting after sync keeps glitches out
    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            src_meta <= {SOURCES{1'b0}};
            src_sync <= {SOURCES{1'b0}};
            src_prev <= 1'b0;
        end else begin
            src_meta <= clock_sources_i;
            src_sync <= src_meta;
            src_prev <= src_level;
        end
    end

    // source faster than half sys_clk is lost; the system clock itself cannot be a source
    assign src_level = src_sync[clock_source_select_i];
    assign tick      = enable_i & src_level & ~src_prev;

    ////////////////////////////////////////////////////////////////////////////////////////
    // full adder; carry is the bit above the accumulator, rate f*inc/2^20
    assign sum = {1'b0, acc} + {1'b0, inc_buf};

    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            acc                     <= `ACC_RESET;
            accumulator_carry_out_o <= 1'b0;
        end else begin
            accumulator_carry_out_o <= tick & sum[`ACC_WIDTH];
            if (tick) begin
                acc <= sum[`ACC_WIDTH-1:0];
            end else begin
                // writes in a tick cycle are dropped; the adder result is kept
                if (acc_low_we_i)
                    acc[`HIGH_BYTE_LSB-1:`LOW_BYTE_LSB] <= wdata_i;
                if (acc_high_we_i)
                    acc[`UPPER_BYTE_LSB-1:`HIGH_BYTE_LSB] <= wdata_i;
                if (acc_upper_we_i)
                    acc[`ACC_WIDTH-1:`UPPER_BYTE_LSB] <= wdata_i[`UPPER_BYTE_WIDTH-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // holding registers software sees; the buffer behind them is never visible
    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            inc_hold <= `INC_RESET;
        end else begin
            if (inc_low_we_i)
                inc_hold[`HIGH_BYTE_LSB-1:`LOW_BYTE_LSB] <= wdata_i;
            if (inc_high_we_i)
                inc_hold[`UPPER_BYTE_LSB-1:`HIGH_BYTE_LSB] <= wdata_i;
            if (inc_upper_we_i)
                inc_hold[`ACC_WIDTH-1:`UPPER_BYTE_LSB] <= wdata_i[`UPPER_BYTE_WIDTH-1:0];
        end
    end

    // buffer load: enabled waits two ticks after a low write, disabled copies one cycle after any increment write
    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            inc_buf   <= `INC_RESET;
            load_pend <= 1'b0;
            load_cnt  <= 2'h0;
        end else if (!enable_i) begin
            load_pend <= 1'b0;
            load_cnt  <= 2'h0;
            if (inc_low_we_i | inc_high_we_i | inc_upper_we_i)
                load_pend <= 1'b1;
            if (load_pend)
                inc_buf <= inc_hold;
        end else if (inc_low_we_i) begin
            // relies on software writing upper and high first
            load_pend <= 1'b1;
            load_cnt  <= 2'h0;
        end else if (load_pend && tick) begin
            if (load_cnt == `LOAD_DELAY_TICKS - 2'h1) begin
                inc_buf   <= inc_hold;
                load_pend <= 1'b0;
                load_cnt  <= 2'h0;
            end else begin
                load_cnt <= load_cnt + 2'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // sticky flag: a new overflow in the clear cycle wins over the clear
    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i)
            overflow_event_flag_o <= 1'b0;
        else if (tick & sum[`ACC_WIDTH])
            overflow_event_flag_o <= 1'b1;
        else if (flag_clear_i)
            overflow_event_flag_o <= 1'b0;
    end

    nco_pulse_shaper u_shaper (
        .sys_clk_i    (sys_clk_i),
        .rstn_i       (rstn_i),
        .enable_i     (enable_i),
        .tick_i       (tick),
        .carry_i      (sum[`ACC_WIDTH]),
        .pulse_mode_i (pulse_mode_select_i),
        .width_sel_i  (pulse_width_select_i),
        .invert_i     (output_invert_i),
        .out_o        (oscillator_out_o)
    );

    assign increment_low_byte_o     = inc_hold[7:0];
    assign increment_high_byte_o    = inc_hold[15:8];
    assign increment_upper_byte_o   = {4'h0, inc_hold[19:16]};
    assign accumulator_low_byte_o   = acc[7:0];
    assign accumulator_high_byte_o  = acc[15:8];
    assign accumulator_upper_byte_o = {4'h0, acc[19:16]};

endmodule

`default_nettype wire

// *** testbench/nco_checker_asserts.sv ***
// port-level checker for the phase accumulator oscillator
// assumes one sys_clk_i domain and one-cycle write strobes
`timescale 1ns/1ns
`default_nettype none
module nco_checker (
    input wire       sys_clk_i,               // system clock
    input wire       rstn_i,                  // async reset, low
    input wire       enable_i,                // module enable
    input wire       pulse_mode_select_i,     // pulse or fixed duty
    input wire       output_invert_i,         // output invert
    input wire [7:0] wdata_i,                 // write byte
    input wire       inc_low_we_i,            // increment low write
    input wire       acc_low_we_i,            // accumulator low write
    input wire       acc_high_we_i,           // accumulator high write
    input wire       acc_upper_we_i,          // accumulator upper write
    input wire       flag_clear_i,            // flag clear
    input wire [7:0] increment_low_byte_o,    // increment low
    input wire [7:0] increment_upper_byte_o,  // increment upper
    input wire [7:0] accumulator_low_byte_o,  // accumulator low
    input wire [7:0] accumulator_high_byte_o, // accumulator high
    input wire [7:0] accumulator_upper_byte_o,// accumulator upper
    input wire       accumulator_carry_out_o, // raw overflow
    input wire       overflow_event_flag_o,   // sticky flag
    input wire       oscillator_out_o         // shaped output
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);
    ////////////////////////////////////////////////////////////////////////
    // whole accumulator and any software write to it
    wire [19:0] acc = {accumulator_upper_byte_o[3:0], accumulator_high_byte_o,
                       accumulator_low_byte_o};
    wire        acc_we = acc_low_we_i | acc_high_we_i | acc_upper_we_i;
    ////////////////////////////////////////////////////////////////////////
    // ticks are at least two cycles apart, so a carry never lasts longer
    carry_single_a: assert property (accumulator_carry_out_o |=> !accumulator_carry_out_o)
        else $error("carry held past one cycle");
    flag_sets_a: assert property (accumulator_carry_out_o |-> overflow_event_flag_o)
        else $error("overflow without flag");
    flag_sticky_a: assert property (overflow_event_flag_o && !flag_clear_i |=> overflow_event_flag_o)
        else $error("flag dropped without clear");
    idle_quiet_a: assert property ((!enable_i) [*3] |-> !accumulator_carry_out_o)
        else $error("overflow while disabled");
    acc_frozen_a: assert property ((!enable_i && !acc_we) [*2] |=> $stable(acc))
        else $error("accumulator moved while disabled");
    inc_load_a: assert property (inc_low_we_i |=> increment_low_byte_o == $past(wdata_i))
        else $error("increment low byte not written");
    acc_load_a: assert property (acc_low_we_i && !enable_i |=> accumulator_low_byte_o == $past(wdata_i))
        else $error("accumulator low byte not written");
    upper_pad_a: assert property (accumulator_upper_byte_o[7:4] == 4'h0 && increment_upper_byte_o[7:4] == 4'h0)
        else $error("unused upper bits set");
    pulse_start_a: assert property (enable_i && pulse_mode_select_i && accumulator_carry_out_o |-> oscillator_out_o != output_invert_i)
        else $error("pulse not active after overflow");
    idle_level_a: assert property ((!enable_i) [*2] |-> oscillator_out_o == output_invert_i)
        else $error("output not idle while disabled");
    // main scenarios reached
    cover property (pulse_mode_select_i && accumulator_carry_out_o);
    cover property (!pulse_mode_select_i && accumulator_carry_out_o);
    cover property (overflow_event_flag_o && flag_clear_i);
endmodule
bind phase_accumulator_oscillator nco_checker chk (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
    .enable_i(enable_i), .pulse_mode_select_i(pulse_mode_select_i),
    .output_invert_i(output_invert_i), .wdata_i(wdata_i), .inc_low_we_i(inc_low_we_i),
    .acc_low_we_i(acc_low_we_i), .acc_high_we_i(acc_high_we_i),
    .acc_upper_we_i(acc_upper_we_i), .flag_clear_i(flag_clear_i),
    .increment_low_byte_o(increment_low_byte_o), .increment_upper_byte_o(increment_upper_byte_o),
    .accumulator_low_byte_o(accumulator_low_byte_o), .accumulator_high_byte_o(accumulator_high_byte_o),
    .accumulator_upper_byte_o(accumulator_upper_byte_o),
    .accumulator_carry_out_o(accumulator_carry_out_o),
    .overflow_event_flag_o(overflow_event_flag_o), .oscillator_out_o(oscillator_out_o));
`default_nettype wire

// *** testbench/phase_accumulator_oscillator_bench.sv ***
// self-checking bench for the phase accumulator oscillator
// assumes the design and the bound checker are compiled before it
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin failures++; \
    $display("wrong value %s expected %h seen %h", n, e, g); end end
module phase_accumulator_oscillator_bench;
    reg        sys_clk = 1'b0;
    reg        rstn = 1'b0;
    reg        en = 1'b0, pm = 1'b0, inv = 1'b0, fclr = 1'b0, tgl = 1'b0;
    reg [2:0]  pulse_width_select = 3'h0;
    reg [3:0]  sel = 4'h0;
    reg [15:0] src = 16'h0;
    reg [7:0]  wd = 8'h0;
    reg [5:0]  we = 6'h0;
    reg [31:0] seed = 32'he91a44a6;
    reg [19:0] a0, i1, i2;
    reg [63:0] tot;
    wire [7:0] il, ih, iu, al, ah, au;
    wire       cy, fl, out;
    integer    failures = 0, num_checks = 0, ncy = 0, n0, r, k1, k2;
    ////////////////////////////////////////////////////////////////////////
    phase_accumulator_oscillator DUT (.sys_clk_i(sys_clk), .rstn_i(rstn), .enable_i(en),
        .pulse_mode_select_i(pm), .pulse_width_select_i(pulse_width_select), .output_invert_i(inv),
        .clock_source_select_i(sel), .clock_sources_i(src), .wdata_i(wd),
        .inc_low_we_i(we[0]), .inc_high_we_i(we[1]), .inc_upper_we_i(we[2]),
        .acc_low_we_i(we[3]), .acc_high_we_i(we[4]), .acc_upper_we_i(we[5]),
        .flag_clear_i(fclr), .increment_low_byte_o(il), .increment_high_byte_o(ih),
        .increment_upper_byte_o(iu), .accumulator_low_byte_o(al),
        .accumulator_high_byte_o(ah), .accumulator_upper_byte_o(au),
        .accumulator_carry_out_o(cy), .overflow_event_flag_o(fl), .oscillator_out_o(out));
    // 25 MHz clock; overflow pulses counted as they pass
    always #20 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (cy === 1'b1) ncy <= ncy + 1;
    function [31:0] xs(input [31:0] x);
        begin
            x = x ^ (x << 13);
            x = x ^ (x >> 17);
            xs = x ^ (x << 5);
        end
    endfunction
    ////////////////////////////////////////////////////////////////////////
    // one byte strobe; the idle cycle after it keeps drivers single per step
    task wr(input integer b, input [7:0] d);
        begin
            @(negedge sys_clk);
            wd = d;
            we[b] = 1'b1;
            @(negedge sys_clk);
            we = 6'h0;
        end
    endtask
    task wr3(input integer g, input [19:0] v);
        begin
            wr(g + 2, {4'h0, v[19:16]});
            wr(g + 1, v[15:8]);
            wr(g, v[7:0]);
        end
    endtask
    // k rises of the chosen source, 8 cycles apart; others carry slow noise
    task ticks(input integer k);
        integer j;
        begin
            for (j = 0; j < k; j++) begin
                @(negedge sys_clk);
                seed = xs(seed);
                src = {seed[15:0]} | (16'h1 << sel);
                repeat (4) @(negedge sys_clk);
                seed = xs(seed);
                src = seed[15:0] & ~(16'h1 << sel);
                repeat (3) @(negedge sys_clk);
            end
        end
    endtask
    task conclude;
        begin
            if (failures == 0 && num_checks > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    // hang guard at 20000 cycles, far beyond the expected 1200 cycles at most
    initial begin
        #800000;
        failures++;
        conclude;
    end
    initial begin
        repeat (4) @(negedge sys_clk);
        rstn = 1'b1;
        `CHK("reset accumulator", 24'h0, {au, ah, al})
        for (r = 0; r < 10; r++) begin
            seed = xs(seed);
            a0 = seed[19:0];
            k1 = seed[22:20];
            k2 = 2 + seed[24:23];
            inv = seed[25];
            pulse_width_select = seed[28:26];
            sel = seed[31:28];
            seed = xs(seed);
            i1 = seed[19:0];
            seed = xs(seed);
            i2 = seed[19:0];
            pm = (r >= 7);
            // corners: wrap on every tick, then an exact wrap to zero
            if (r == 0) begin
                a0 = 20'hfffff;
                i1 = 20'hfffff;
            end
            if (r == 1) begin
                a0 = 20'hffff0;
                i1 = 20'h00010;
                i2 = 20'h00000;
            end
            src = src & ~(16'h1 << sel);
            wr3(0, i1);
            wr3(3, a0);
            wr(0, i1[7:0]);
            @(negedge sys_clk);
            fclr = 1'b1;
            @(negedge sys_clk);
            fclr = 1'b0;
            `CHK("increment", {4'h0, i1}, {iu, ih, il})
            `CHK("accumulator", {4'h0, a0}, {au, ah, al})
            `CHK("flag after clear", 1'b0, fl)
            n0 = ncy;
            en = 1'b1;
            ticks(k1);
            wr3(0, i2);
            ticks(k2);
            tot = a0 + i1 * (k1 + 2) + i2 * (k2 - 2);
            `CHK("accumulator sum", {4'h0, tot[19:0]}, {au, ah, al})
            `CHK("overflows", tot[51:20], ncy - n0)
            `CHK("flag", tot[51:20] != 0, fl)
            if (!pm) begin
                // disable forces the toggle level low, so each round starts from zero
                tgl = tot[20];
                `CHK("toggle output", tgl ^ inv, out)
            end
            en = 1'b0;
        end
        conclude;
    end
endmodule
`default_nettype wire
